// file: out_path_cfg_pkg.sv
// Register map, field positions and reset values of the output path configuration bank
package out_path_cfg_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_RES_CTRL     = 8'h1b;
  localparam logic [7:0] IDX_LANE_DELAY   = 8'h1e;
  localparam logic [7:0] IDX_PAT_LOW      = 8'h20;
  localparam logic [7:0] IDX_PAT_MID      = 8'h21;
  localparam logic [7:0] IDX_PAT_HIGH     = 8'h22;
  localparam logic [7:0] IDX_PATH_CTRL    = 8'h24;
  localparam logic [7:0] IDX_DECIM_CTRL   = 8'h25;
  localparam logic [7:0] IDX_STATUS       = 8'h30;

  // Field positions
  localparam int RES_EN_BIT     = 7;
  localparam int TWENTY_BIT     = 6;
  localparam int RES_CODE_LSB   = 3;
  localparam int DATA_DEL_LSB   = 2;
  localparam int CLK_DEL_LSB    = 0;
  localparam int SCR_BIT        = 6;
  localparam int AVG_BIT        = 5;
  localparam int SRC_LSB        = 3;
  localparam int DSP_BIT        = 2;
  localparam int DDC_BIT        = 1;
  localparam int MUX_BIT        = 7;
  localparam int RATIO_LSB      = 4;
  localparam int KIND_BIT       = 3;

  // Reset values
  localparam logic [7:0]  RES_CTRL_RST   = 8'h00;
  localparam logic [7:0]  LANE_DELAY_RST = 8'h00;
  localparam logic [19:0] PATTERN_RST    = 20'hffc00;
  localparam logic [7:0]  PATH_CTRL_RST  = 8'h00;
  localparam logic [7:0]  DECIM_CTRL_RST = 8'h00;

  // Resolution codes and resolved widths
  localparam logic [2:0] RES_CODE_18 = 3'h0;
  localparam logic [2:0] RES_CODE_16 = 3'h1;
  localparam logic [2:0] RES_CODE_14 = 3'h2;
  localparam logic [4:0] BITS_20 = 5'h14;
  localparam logic [4:0] BITS_18 = 5'h12;
  localparam logic [4:0] BITS_16 = 5'h10;
  localparam logic [4:0] BITS_14 = 5'h0e;

  // Delay codes
  localparam logic [1:0] DEL_NONE  = 2'h0;
  localparam logic [1:0] DEL_ADV50 = 2'h1;
  localparam logic [1:0] DEL_LAG50 = 2'h2;
  localparam logic [1:0] DEL_LAG100 = 2'h3;
  // Signed delay in 50 ps steps
  localparam logic signed [2:0] STEP_NONE  = 3'sh0;
  localparam logic signed [2:0] STEP_ADV50 = -3'sh1;
  localparam logic signed [2:0] STEP_LAG50 = 3'sh1;
  localparam logic signed [2:0] STEP_LAG100 = 3'sh2;

  // Down-converter input sources
  typedef enum logic [1:0]
  {
    SRC_A   = 2'b00,
    SRC_B   = 2'b01,
    SRC_AVG = 2'b10
  } source_t;

  // Bus slave states
  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b00,
    BUS_DONE = 2'b01
  } bus_state_t;

endpackage

// file: out_path_cfg.sv
// Output path configuration register bank with Avalon-MM slave
`timescale 1ns/1ns

module out_path_cfg
  import out_path_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                reset_in,
  // Avalon-MM slave
  input  wire logic [9:0]          avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic      [31:0]         avs_readdata_out,
  output logic                     avs_waitrequest_out,
  // Resolved output path controls
  output logic      [4:0]          output_bits_out,
  output logic signed [2:0]        data_lane_delay_out,
  output logic signed [2:0]        data_clock_delay_out,
  output logic      [19:0]         frame_clock_pattern_out,
  output logic                     scrambler_active_out,
  output logic                     channel_average_active_out,
  output logic                     processing_path_active_out,
  output logic                     downconverter_active_out,
  output logic                     decimation_real_out,
  output logic      [2:0]          decimation_ratio_out,
  output logic      [1:0]          downconv0_source_out,
  output logic      [1:0]          downconv1_source_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0]  res_ctrl_r;
  logic [7:0]  lane_delay_r;
  logic [19:0] pattern_r;
  logic        scrambler_enable_r;
  logic [7:0]  path_ctrl_r;
  logic [7:0]  decim_ctrl_r;
  bus_state_t  bus_state_r;
  logic [7:0]  idx;
  logic        wr_take;
  logic        rd_take;
  logic        wr_lane0;
  logic [7:0]  wdata;
  logic [7:0]  rdata_nxt;

  // Word index from byte address; only lane 0 carries data
  assign idx      = avs_address_in[9:2];
  assign wdata    = avs_writedata_in[7:0];
  assign wr_take  = avs_write_in && (bus_state_r == BUS_DONE);  // Lands where waitrequest is low
  assign rd_take  = avs_read_in && (bus_state_r == BUS_IDLE);
  assign wr_lane0 = wr_take && avs_byteenable_in[0];

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, request accepted on second edge
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      bus_state_r <= BUS_IDLE;
    else
    begin
      case (bus_state_r)
        BUS_IDLE:
          if (avs_read_in || avs_write_in)
            bus_state_r <= BUS_DONE;
        BUS_DONE:
          bus_state_r <= BUS_IDLE;
        default:
          bus_state_r <= BUS_IDLE;
      endcase
    end
  end

  // Waitrequest low only in the completing cycle
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      avs_waitrequest_out <= 1'b1;
    else
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && bus_state_r == BUS_IDLE);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register writes, stored verbatim for readback except IDX_PAT_HIGH, which keeps only bits 3:0 and SCR_BIT
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      res_ctrl_r   <= RES_CTRL_RST;
      lane_delay_r <= LANE_DELAY_RST;
      pattern_r    <= PATTERN_RST;
      scrambler_enable_r     <= 1'b0;
      path_ctrl_r  <= PATH_CTRL_RST;
      decim_ctrl_r <= DECIM_CTRL_RST;
    end
    else if (wr_lane0)
    begin
      case (idx)
        IDX_RES_CTRL:   res_ctrl_r   <= wdata;
        IDX_LANE_DELAY: lane_delay_r <= wdata;
        IDX_PAT_LOW:    pattern_r[7:0]   <= wdata;
        IDX_PAT_MID:    pattern_r[15:8]  <= wdata;
        IDX_PAT_HIGH:
        begin
          pattern_r[19:16] <= wdata[3:0];
          scrambler_enable_r         <= wdata[SCR_BIT];
        end
        IDX_PATH_CTRL:  path_ctrl_r  <= wdata;
        IDX_DECIM_CTRL: decim_ctrl_r <= wdata;
        default:        ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped words read zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (idx)
      IDX_RES_CTRL:   rdata_nxt = res_ctrl_r;
      IDX_LANE_DELAY: rdata_nxt = lane_delay_r;
      IDX_PAT_LOW:    rdata_nxt = pattern_r[7:0];
      IDX_PAT_MID:    rdata_nxt = pattern_r[15:8];
      IDX_PAT_HIGH:   rdata_nxt = {1'b0, scrambler_enable_r, 2'b00, pattern_r[19:16]};
      IDX_PATH_CTRL:  rdata_nxt = path_ctrl_r;
      IDX_DECIM_CTRL: rdata_nxt = decim_ctrl_r;
      IDX_STATUS:     rdata_nxt = {1'b0, scrambler_active_out, channel_average_active_out,
                                   output_bits_out};
      default:        rdata_nxt = 8'h00;
    endcase
  end

  // Read data registered at the end of the wait cycle, valid in the completing cycle
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      avs_readdata_out <= 32'h0;
    else if (rd_take)
      avs_readdata_out <= {24'h0, rdata_nxt};
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output resolution
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      output_bits_out <= BITS_18;
    else if (res_ctrl_r[TWENTY_BIT])
      output_bits_out <= BITS_20;
    else if (res_ctrl_r[RES_EN_BIT] || path_ctrl_r[DSP_BIT])
    begin
      case (res_ctrl_r[RES_CODE_LSB +: 3])
        RES_CODE_16: output_bits_out <= BITS_16;
        RES_CODE_14: output_bits_out <= BITS_14;
        RES_CODE_18: output_bits_out <= BITS_18;
        default:     output_bits_out <= BITS_18;
      endcase
    end
    else
      output_bits_out <= BITS_18;
  end

  // Delay code to signed 50 ps steps
  function automatic logic signed [2:0] delay_steps(input logic [1:0] code);
    case (code)
      DEL_ADV50:  delay_steps = STEP_ADV50;
      DEL_LAG50:  delay_steps = STEP_LAG50;
      DEL_LAG100: delay_steps = STEP_LAG100;
      default:    delay_steps = STEP_NONE;
    endcase
  endfunction

  // Lane and clock delay
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      data_lane_delay_out  <= STEP_NONE;
      data_clock_delay_out <= STEP_NONE;
    end
    else
    begin
      data_lane_delay_out  <= delay_steps(lane_delay_r[DATA_DEL_LSB +: 2]);
      data_clock_delay_out <= delay_steps(lane_delay_r[CLK_DEL_LSB +: 2]);
    end
  end

  // Path enables and pattern
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      frame_clock_pattern_out    <= PATTERN_RST;
      scrambler_active_out       <= 1'b0;
      channel_average_active_out <= 1'b0;
      processing_path_active_out <= 1'b0;
      downconverter_active_out   <= 1'b0;
      decimation_real_out        <= 1'b0;
      decimation_ratio_out       <= 3'h0;
    end
    else
    begin
      frame_clock_pattern_out    <= pattern_r;
      scrambler_active_out       <= scrambler_enable_r && path_ctrl_r[DSP_BIT];
      channel_average_active_out <= path_ctrl_r[AVG_BIT];
      processing_path_active_out <= path_ctrl_r[DSP_BIT];
      downconverter_active_out   <= path_ctrl_r[DDC_BIT];
      decimation_real_out        <= decim_ctrl_r[KIND_BIT];
      decimation_ratio_out       <= decim_ctrl_r[RATIO_LSB +: 3];
    end
  end

  // Down-converter input routing
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      downconv0_source_out <= SRC_A;
      downconv1_source_out <= SRC_B;
    end
    else if (!decim_ctrl_r[MUX_BIT])
    begin
      downconv0_source_out <= SRC_A;
      downconv1_source_out <= SRC_B;
    end
    else
    begin
      case (path_ctrl_r[SRC_LSB +: 2])
        2'h1:
        begin
          downconv0_source_out <= SRC_A;
          downconv1_source_out <= SRC_A;
        end
        2'h2:
        begin
          downconv0_source_out <= SRC_B;
          downconv1_source_out <= SRC_B;
        end
        2'h3:
        begin
          downconv0_source_out <= SRC_AVG;
          downconv1_source_out <= SRC_AVG;
        end
        default:
        begin
          downconv0_source_out <= SRC_A;
          downconv1_source_out <= SRC_B;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_mux_route_avg;
    decim_ctrl_r[MUX_BIT] && path_ctrl_r[SRC_LSB +: 2] == 2'h3;
  endsequence

  property p_scr_gate;
    @(posedge core_clk_in) disable iff (reset_in)
    scrambler_active_out |-> $past(path_ctrl_r[DSP_BIT]) && $past(scrambler_enable_r);
  endproperty
  a_scr_gate: assert property (p_scr_gate) else $error("scrambler active without path");

  property p_res_code;
    @(posedge core_clk_in) disable iff (reset_in)
    (res_ctrl_r == 8'h88) |=> output_bits_out == BITS_16;
  endproperty
  a_res_code: assert property (p_res_code) else $error("16-bit code not applied");

  property p_twenty;
    @(posedge core_clk_in) disable iff (reset_in)
    res_ctrl_r[TWENTY_BIT] |=> output_bits_out == BITS_20;
  endproperty
  a_twenty: assert property (p_twenty) else $error("20-bit mode not applied");

  property p_lane_delay;
    @(posedge core_clk_in) disable iff (reset_in)
    lane_delay_r[3:2] == 2'h1 |=> data_lane_delay_out == -3'sh1;
  endproperty
  a_lane_delay: assert property (p_lane_delay) else $error("lane advance wrong");

  property p_clk_delay;
    @(posedge core_clk_in) disable iff (reset_in)
    lane_delay_r[1:0] == 2'h3 |=> data_clock_delay_out == 3'sh2;
  endproperty
  a_clk_delay: assert property (p_clk_delay) else $error("clock delay wrong");

  property p_avg_route;
    @(posedge core_clk_in) disable iff (reset_in)
    s_mux_route_avg |=> downconv0_source_out == SRC_AVG && downconv1_source_out == SRC_AVG;
  endproperty
  a_avg_route: assert property (p_avg_route) else $error("average route wrong");

  property p_mux_off;
    @(posedge core_clk_in) disable iff (reset_in)
    !decim_ctrl_r[MUX_BIT] |=> downconv0_source_out == SRC_A && downconv1_source_out == SRC_B;
  endproperty
  a_mux_off: assert property (p_mux_off) else $error("routing while mux off");

  property p_pattern_write;
    @(posedge core_clk_in) disable iff (reset_in)
    (wr_lane0 && idx == IDX_PAT_MID) |=> ##1 frame_clock_pattern_out[15:8] == $past(wdata, 2);
  endproperty
  a_pattern_write: assert property (p_pattern_write) else $error("pattern mid lost");

  property p_converter_en;
    @(posedge core_clk_in) disable iff (reset_in)
    (wr_lane0 && idx == IDX_PATH_CTRL) |=> ##1 downconverter_active_out == $past(wdata[1], 2);
  endproperty
  a_converter_en: assert property (p_converter_en) else $error("converter enable wrong");

endmodule

// file: frame_rx_model.sv
// Host receiver model that judges the frame pattern against the output resolution
`timescale 1ns/1ns
module frame_rx_model
  import out_path_cfg_pkg::*;
(
  // Clock
  input  wire logic        core_clk_in,
  // Configuration seen by the receiver
  input  wire logic [19:0] frame_clock_pattern_in,
  input  wire logic [4:0]  output_bits_in,
  // Verdict
  output logic             pattern_ok_out
);
  // Pattern the receiver frames on, path off or real decimation
  always_ff @(posedge core_clk_in)
  begin
    case (output_bits_in)
      BITS_14: pattern_ok_out <= (frame_clock_pattern_in == 20'hfe000);
      BITS_16: pattern_ok_out <= (frame_clock_pattern_in == 20'hff000);
      BITS_18: pattern_ok_out <= (frame_clock_pattern_in == 20'hff800);
      default: pattern_ok_out <= (frame_clock_pattern_in == 20'hffc00);
    endcase
  end
endmodule

// file: adc_output_path_config_tb_top.sv
// Self-checking testbench for the output path configuration bank
`timescale 1ns/1ns
module adc_output_path_config_tb_top
  import out_path_cfg_pkg::*;
  ;
  logic               core_clk_in, reset_in, avs_read_in, avs_write_in;
  logic        [9:0]  avs_address_in;
  logic        [31:0] avs_writedata_in, avs_readdata_out;
  logic        [3:0]  avs_byteenable_in;
  logic               avs_waitrequest_out, scr, avg, dsp, ddc, real_k, pattern_ok;
  logic        [4:0]  output_bits_out;
  logic signed [2:0]  lane_del, clk_del;
  logic        [19:0] pattern;
  logic        [2:0]  ratio;
  logic        [1:0]  src0, src1;
  int                 fails, tests_run;

  out_path_cfg i_out_path_cfg (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .output_bits_out(output_bits_out),
    .data_lane_delay_out(lane_del), .data_clock_delay_out(clk_del),
    .frame_clock_pattern_out(pattern), .scrambler_active_out(scr),
    .channel_average_active_out(avg), .processing_path_active_out(dsp),
    .downconverter_active_out(ddc), .decimation_real_out(real_k),
    .decimation_ratio_out(ratio), .downconv0_source_out(src0),
    .downconv1_source_out(src1));
  frame_rx_model i_frame_rx_model (.core_clk_in(core_clk_in),
    .frame_clock_pattern_in(pattern), .output_bits_in(output_bits_out),
    .pattern_ok_out(pattern_ok));

  ////////////////////////////////////////////////////////////////
  // Clock
  always #5 core_clk_in = ~core_clk_in;

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Counts and verdict, then stop
  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One bus transfer held until waitrequest is seen low
  task automatic bus_op(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd);
    int n;
    @(posedge core_clk_in);
    avs_address_in   <= {idx, 2'b00};
    avs_writedata_in <= {24'h0, wd};
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    n = 0;
    do
    begin
      @(posedge core_clk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 20);
    rd = avs_readdata_out;
    if (n >= 20)
    begin
      fails++;
      report_and_stop();
    end
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus_op(1'b1, idx, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] x;
    bus_op(1'b0, idx, 8'h00, x);
    check(x, {24'h0, e});
  endtask

  // Let the register and then the outputs update
  task automatic settle;
    repeat (2) @(posedge core_clk_in);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(IDX_LANE_DELAY, 8'h00);
    rd_chk(IDX_PAT_LOW, 8'h00);
    rd_chk(IDX_PAT_MID, 8'hfc);
    rd_chk(IDX_PAT_HIGH, 8'h0f);
    rd_chk(IDX_PATH_CTRL, 8'h00);
    rd_chk(IDX_DECIM_CTRL, 8'h00);
    rd_chk(8'h3f, 8'h00);
    rd_chk(IDX_STATUS, 8'h12);
    check(32'(pattern), 32'(PATTERN_RST));
    $display("test reset done");
  endtask

  task automatic t_res;
    logic [4:0] bits [3] = '{BITS_18, BITS_16, BITS_14};
    for (int i = 0; i < 3; i++)
    begin
      wr(IDX_RES_CTRL, {2'b10, i[2:0], 3'h0});
      settle();
      check(32'(output_bits_out), 32'(bits[i]));
    end
    wr(IDX_RES_CTRL, 8'h40);
    settle();
    check(32'(output_bits_out), 32'(BITS_20));
    // Write with byte lane 0 off must leave the register alone
    avs_byteenable_in <= 4'h0;
    wr(IDX_RES_CTRL, 8'h88);
    avs_byteenable_in <= 4'h1;
    rd_chk(IDX_RES_CTRL, 8'h40);
    $display("test resolution done");
  endtask

  task automatic t_delay;
    logic signed [2:0] steps [4] = '{STEP_NONE, STEP_ADV50, STEP_LAG50, STEP_LAG100};
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_LANE_DELAY, {4'h0, i[1:0], 2'(3 - i)});
      settle();
      check(32'(lane_del), 32'(steps[i]));
      check(32'(clk_del), 32'(steps[3 - i]));
      rd_chk(IDX_LANE_DELAY, {4'h0, i[1:0], 2'(3 - i)});
    end
    $display("test delay done");
  endtask

  task automatic t_pattern;
    wr(IDX_PAT_LOW, 8'h00);
    wr(IDX_PAT_MID, 8'he0);
    wr(IDX_PAT_HIGH, 8'h4f);
    wr(IDX_RES_CTRL, 8'h90);
    settle();
    check(32'(pattern), 32'h000fe000);
    check(32'(output_bits_out), 32'(BITS_14));
    check(32'(pattern_ok), 32'h1);
    check(32'(scr), 32'h0);
    rd_chk(IDX_PAT_HIGH, 8'h4f);
    wr(IDX_PATH_CTRL, 8'h04);
    settle();
    check(32'({scr, dsp}), 32'h3);
    rd_chk(IDX_STATUS, 8'h4e);
    wr(IDX_PAT_HIGH, 8'h0f);
    settle();
    check(32'(scr), 32'h0);
    $display("test pattern done");
  endtask

  task automatic t_path;
    logic [3:0] srcs [4] = '{4'b0001, 4'b0000, 4'b0101, 4'b1010};
    wr(IDX_PATH_CTRL, 8'h3e);
    settle();
    check(32'({avg, dsp, ddc}), 32'h7);
    check(32'({src0, src1}), 32'h1);
    wr(IDX_DECIM_CTRL, 8'hb8);
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_PATH_CTRL, {3'b001, i[1:0], 3'b110});
      settle();
      check(32'({src0, src1}), 32'(srcs[i]));
    end
    check(32'(real_k), 32'h1);
    check(32'(ratio), 32'h3);
    wr(IDX_DECIM_CTRL, 8'h00);
    wr(IDX_PATH_CTRL, 8'h00);
    settle();
    check(32'({ratio, real_k, avg, dsp, ddc}), 32'h0);
    check(32'({src0, src1}), 32'h1);
    $display("test path done");
  endtask

  // Reset in mid-run returns the written lane delay and path control fields to their defaults
  task automatic t_rereset;
    wr(IDX_LANE_DELAY, 8'h0a);
    wr(IDX_PATH_CTRL, 8'h26);
    settle();
    check(32'({avg, dsp}), 32'h3);
    check(32'(lane_del), 32'(STEP_LAG50));
    @(posedge core_clk_in);
    reset_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    check(32'({avs_waitrequest_out, avg, dsp}), 32'h4);
    check(32'(lane_del), 32'(STEP_NONE));
    reset_in <= 1'b0;
    rd_chk(IDX_LANE_DELAY, 8'h00);
    rd_chk(IDX_PATH_CTRL, 8'h00);
    $display("test mid-run reset done");
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    core_clk_in       = 1'b0;
    reset_in          = 1'b1;
    avs_read_in       = 1'b0;
    avs_write_in      = 1'b0;
    avs_address_in    = 10'h000;
    avs_writedata_in  = 32'h0;
    avs_byteenable_in = 4'h1;
    fails             = 0;
    tests_run         = 0;
    repeat (10) @(posedge core_clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_res();
    t_delay();
    t_pattern();
    t_path();
    t_rereset();
    report_and_stop();
  end
endmodule
